/* hw/ppm_pin_mux.sv */
// Purpose: Priority sharing of 20 of the 30 port pins between peripherals and the plain port.
// Assumes: One clock pclk at 50 MHz; APB slave with no wait states.
// Notes:   Pad drive and peripheral inputs are registered, so ownership changes
//          reach the pins one cycle after the enable bits change.
// Overview of operation
// - Highest ranked enabled function owns a shared pin; lower ones are blocked.
// - Pin passes to the next function only once the higher one switches off.
// - Pull-up follows the same ranking; only the owner's pull-up acts.
// - Direction and pull-up writes are stored but unseen while a function owns the pin, except on interrupt pins, where an output direction ends ownership.
// - Port writes update only the data latch while a function owns the pin.
// - P0.2 carries the secondary PWM output when its enable bit is set.
// - P0.3 carries the primary PWM output at top priority when enabled.
// - Otherwise P0.3 is the timer-four control input under three enable conditions.
// - P0.6 is external interrupt two when enabled and set as input.
// - P0.7 is external interrupt three when enabled and set as input.
// - P2.0 is serial receive with automatic pull-up once receive is enabled.
// - P2.1 becomes serial transmit once software writes the transmit buffer.
// - P2.5 is the PWM fault input when fault enable is set.
// - P3.4-P3.7 go analog when enabled, converter on and channel selected.
// - P4.4 becomes converter reference input when reference select is set.
// - P4.0-P4.3: analog first, then port-four interrupts, then plain port.
// - P5.0-P5.2 become oscillator and reset pins only by code option.
// - P5.3 drives the buzzer output at top priority when buzzer is enabled.
// - Otherwise P5.3 is timer-three clock input with pull-up when selected.
`timescale 1ns/1ps
module ppm_pin_mux (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [7:0]       paddr,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  input  wire logic [47:0]      pin_in,
  output ppm_pkg::ppm_pad_t     pad,
  input  wire ppm_pkg::ppm_src_t src,
  output ppm_pkg::ppm_fn_t      fn,
  output logic [47:0]           owned,
  input  wire logic             osc_option_strap,
  input  wire logic             reset_option_strap
);

  logic [47:0]       pin_meta;
  logic [47:0]       pin_sync;
  logic [1:0]        strap_meta;
  logic [1:0]        strap_sync;
  logic [1:0]        strap_wait;
  logic              osc_option;
  logic              reset_option;
  logic [47:0]       data_bits;
  logic [47:0]       pin_direction_bits;
  logic [47:0]       pin_pullup_bits;
  logic [7:0]        pwm_enable_register;
  logic [7:0]        timer_four_control_register;
  logic [7:0]        irq_enable_register_one;
  logic [7:0]        irq_source_enable_register;
  logic [7:0]        serial_control_register;
  logic [7:0]        analog_channel_register;
  logic [7:0]        converter_control_register;
  logic [7:0]        buzzer_control_register;
  logic [7:0]        timer_three_control_register;
  logic              tx_owned;
  logic              wr_en;
  logic              rd_setup;
  logic              addr_hit;
  logic [31:0]       rd_value;
  logic [2:0]        converter_channel_select;
  logic [1:0]        timer_three_clock_select;
  logic              t4_auto_pull;
  logic              t4_active;
  ppm_pkg::ppm_pad_t next_pad;
  ppm_pkg::ppm_fn_t  next_fn;
  logic [47:0]       next_owned;

  assign wr_en    = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign pready   = 1'b1;
  assign pslverr  = psel && penable && !addr_hit;

  assign converter_channel_select = converter_control_register[ppm_pkg::POS_CONV_SCH +: 3];
  assign timer_three_clock_select = timer_three_control_register[ppm_pkg::POS_T3_CLKS +: 2];

  // Pins arrive from outside pclk, so every one is resynchronised first.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_meta <= '0;
      pin_sync <= '0;
    end
    else
    begin
      pin_meta <= pin_in;
      pin_sync <= pin_meta;
    end
  end

  // Code option straps are caught once, after the synchroniser has settled.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      strap_meta   <= 2'h0;
      strap_sync   <= 2'h0;
      strap_wait   <= 2'h0;
      osc_option   <= 1'b0;
      reset_option <= 1'b0;
    end
    else
    begin
      strap_meta <= {reset_option_strap, osc_option_strap};
      strap_sync <= strap_meta;
      if (strap_wait != 2'h3)
      begin
        strap_wait <= strap_wait + 2'h1;
        if (strap_wait == 2'h2)
        begin
          osc_option   <= strap_sync[0];
          reset_option <= strap_sync[1];
        end
      end
    end
  end

  // Port data, direction and pull-up latches always accept writes.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      data_bits          <= {6{ppm_pkg::PORT_RST}};
      pin_direction_bits <= {6{ppm_pkg::PORT_RST}};
      pin_pullup_bits    <= {6{ppm_pkg::PORT_RST}};
    end
    else if (wr_en)
    begin
      for (int p = 0; p < 6; p++)
      begin
        if (paddr == ppm_pkg::OFF_DATA_BASE + 8'(4 * p))
          data_bits[p*8 +: 8] <= pwdata[7:0] & ppm_pkg::PIN_VALID[p*8 +: 8];
        if (paddr == ppm_pkg::OFF_DIR_BASE + 8'(4 * p))
          pin_direction_bits[p*8 +: 8] <= pwdata[7:0] & ppm_pkg::PIN_VALID[p*8 +: 8];
        if (paddr == ppm_pkg::OFF_PULL_BASE + 8'(4 * p))
          pin_pullup_bits[p*8 +: 8] <= pwdata[7:0] & ppm_pkg::PIN_VALID[p*8 +: 8];
      end
    end
  end

  // Enable bits of the sharing peripherals.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pwm_enable_register          <= ppm_pkg::CTRL_RST;
      timer_four_control_register  <= ppm_pkg::CTRL_RST;
      irq_enable_register_one      <= ppm_pkg::CTRL_RST;
      irq_source_enable_register   <= ppm_pkg::CTRL_RST;
      serial_control_register      <= ppm_pkg::CTRL_RST;
      analog_channel_register      <= ppm_pkg::CTRL_RST;
      converter_control_register   <= ppm_pkg::CTRL_RST;
      buzzer_control_register      <= ppm_pkg::CTRL_RST;
      timer_three_control_register <= ppm_pkg::CTRL_RST;
    end
    else if (wr_en)
    begin
      case (paddr)
        ppm_pkg::OFF_PWM_EN:    pwm_enable_register          <= pwdata[7:0];
        ppm_pkg::OFF_T4_CTRL:   timer_four_control_register  <= pwdata[7:0];
        ppm_pkg::OFF_IRQ_EN1:   irq_enable_register_one      <= pwdata[7:0];
        ppm_pkg::OFF_IRQ_SRC:   irq_source_enable_register   <= pwdata[7:0];
        ppm_pkg::OFF_SER_CTRL:  serial_control_register      <= pwdata[7:0];
        ppm_pkg::OFF_AN_CHAN:   analog_channel_register      <= pwdata[7:0];
        ppm_pkg::OFF_CONV_CTRL: converter_control_register   <= pwdata[7:0];
        ppm_pkg::OFF_BUZ_CTRL:  buzzer_control_register      <= pwdata[7:0];
        ppm_pkg::OFF_T3_CTRL:   timer_three_control_register <= pwdata[7:0];
        default:                ;
      endcase
    end
  end

  // Transmit ownership: a buffer write claims the pin, the release bit frees it.
  // A claim in the same cycle as a release wins, so no transmission is lost.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tx_owned <= 1'b0;
    else if (wr_en && paddr == ppm_pkg::OFF_SER_TXBUF)
      tx_owned <= 1'b1;
    else if (wr_en && paddr == ppm_pkg::OFF_SER_CTRL && pwdata[ppm_pkg::BIT_TX_REL])
      tx_owned <= 1'b0;
  end

  always_comb
  begin
    addr_hit = 1'b1;
    rd_value = 32'h0000_0000;
    case (paddr)
      ppm_pkg::OFF_PWM_EN:    rd_value[7:0] = pwm_enable_register;
      ppm_pkg::OFF_T4_CTRL:   rd_value[7:0] = timer_four_control_register;
      ppm_pkg::OFF_IRQ_EN1:   rd_value[7:0] = irq_enable_register_one;
      ppm_pkg::OFF_IRQ_SRC:   rd_value[7:0] = irq_source_enable_register;
      ppm_pkg::OFF_SER_CTRL:  rd_value[7:0] = {serial_control_register[7:2], tx_owned,
                                               serial_control_register[0]};
      ppm_pkg::OFF_SER_TXBUF: rd_value = 32'h0000_0000;
      ppm_pkg::OFF_AN_CHAN:   rd_value[7:0] = analog_channel_register;
      ppm_pkg::OFF_CONV_CTRL: rd_value[7:0] = converter_control_register;
      ppm_pkg::OFF_BUZ_CTRL:  rd_value[7:0] = buzzer_control_register;
      ppm_pkg::OFF_T3_CTRL:   rd_value[7:0] = timer_three_control_register;
      ppm_pkg::OFF_OWN_LO:    rd_value = owned[31:0];
      ppm_pkg::OFF_OWN_HI:    rd_value[15:0] = owned[47:32];
      ppm_pkg::OFF_LEVEL_LO:  rd_value = pin_sync[31:0] & ppm_pkg::PIN_VALID[31:0];
      ppm_pkg::OFF_LEVEL_HI:  rd_value[15:0] = pin_sync[47:32] & ppm_pkg::PIN_VALID[47:32];
      ppm_pkg::OFF_OPTION:    rd_value[1:0] = {reset_option, osc_option};
      default:
      begin
        addr_hit = 1'b0;
        for (int p = 0; p < 6; p++)
        begin
          if (paddr == ppm_pkg::OFF_DATA_BASE + 8'(4 * p))
          begin
            addr_hit      = 1'b1;
            rd_value[7:0] = data_bits[p*8 +: 8];
          end
          if (paddr == ppm_pkg::OFF_DIR_BASE + 8'(4 * p))
          begin
            addr_hit      = 1'b1;
            rd_value[7:0] = pin_direction_bits[p*8 +: 8];
          end
          if (paddr == ppm_pkg::OFF_PULL_BASE + 8'(4 * p))
          begin
            addr_hit      = 1'b1;
            rd_value[7:0] = pin_pullup_bits[p*8 +: 8];
          end
        end
      end
    endcase
  end

  // Read data is captured in the setup cycle so it stands for the access cycle.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (rd_setup)
      prdata <= rd_value;
  end

  assign t4_auto_pull = timer_four_control_register[ppm_pkg::BIT_T4_RUN]
                     && timer_four_control_register[ppm_pkg::BIT_T4_CLKS];
  assign t4_active    = t4_auto_pull
                     || (!timer_four_control_register[ppm_pkg::BIT_T4_CLKS]
                         && timer_four_control_register[ppm_pkg::BIT_T4_CNTS])
                     || (timer_four_control_register[ppm_pkg::BIT_T4_RUN]
                         && timer_four_control_register[ppm_pkg::BIT_T4_MODE2]);

  // Ownership resolution: later, higher ranked checks override the port default.
  always_comb
  begin
    next_owned = '0;
    next_pad.out = data_bits & ppm_pkg::PIN_VALID;
    next_pad.oe  = pin_direction_bits & ppm_pkg::PIN_VALID;
    next_pad.pu  = pin_pullup_bits & ~pin_direction_bits & ppm_pkg::PIN_VALID;
    next_fn = '0;
    next_fn.ext_irq_two_input        = 1'b1;
    next_fn.ext_irq_three_input      = 1'b1;
    next_fn.timer_four_control_input = 1'b1;
    next_fn.serial_rx_data           = 1'b1;
    next_fn.pwm_fault_input          = 1'b1;
    next_fn.timer_three_clock_input  = 1'b1;
    next_fn.port_four_irq_inputs     = 4'hF;
    next_fn.reset_pin_input          = 1'b1;
    next_fn.oscillator_select        = osc_option;
    next_fn.reset_pin_select         = reset_option;

    if (pwm_enable_register[ppm_pkg::BIT_PWM_SEC])
    begin
      next_owned[ppm_pkg::PIN_P02] = 1'b1;
      next_pad.out[ppm_pkg::PIN_P02] = src.pwm_secondary_output;
      next_pad.oe[ppm_pkg::PIN_P02]  = 1'b1;
    end

    if (pwm_enable_register[ppm_pkg::BIT_PWM_PRI])
    begin
      next_owned[ppm_pkg::PIN_P03] = 1'b1;
      next_pad.out[ppm_pkg::PIN_P03] = src.pwm_primary_output;
      next_pad.oe[ppm_pkg::PIN_P03]  = 1'b1;
    end
    else if (t4_active)
    begin
      next_owned[ppm_pkg::PIN_P03] = 1'b1;
      next_pad.oe[ppm_pkg::PIN_P03] = 1'b0;
      next_pad.pu[ppm_pkg::PIN_P03] = t4_auto_pull;
      next_fn.timer_four_control_input = pin_sync[ppm_pkg::PIN_P03];
    end

    if (irq_enable_register_one[ppm_pkg::BIT_EX2] && !pin_direction_bits[ppm_pkg::PIN_P06])
    begin
      next_owned[ppm_pkg::PIN_P06] = 1'b1;
      next_fn.ext_irq_two_input = pin_sync[ppm_pkg::PIN_P06];
    end
    if (irq_enable_register_one[ppm_pkg::BIT_EX3] && !pin_direction_bits[ppm_pkg::PIN_P07])
    begin
      next_owned[ppm_pkg::PIN_P07] = 1'b1;
      next_fn.ext_irq_three_input = pin_sync[ppm_pkg::PIN_P07];
    end

    if (serial_control_register[ppm_pkg::BIT_RX_EN])
    begin
      next_owned[ppm_pkg::PIN_P20] = 1'b1;
      next_pad.oe[ppm_pkg::PIN_P20] = 1'b0;
      next_pad.pu[ppm_pkg::PIN_P20] = 1'b1;
      next_fn.serial_rx_data = pin_sync[ppm_pkg::PIN_P20];
    end
    if (tx_owned)
    begin
      next_owned[ppm_pkg::PIN_P21] = 1'b1;
      next_pad.out[ppm_pkg::PIN_P21] = src.serial_tx_data;
      next_pad.oe[ppm_pkg::PIN_P21]  = 1'b1;
    end
    if (pwm_enable_register[ppm_pkg::BIT_FLT_EN])
    begin
      next_owned[ppm_pkg::PIN_P25] = 1'b1;
      next_fn.pwm_fault_input = pin_sync[ppm_pkg::PIN_P25];
    end

    for (int k = 0; k < 8; k++)
    begin
      if (analog_channel_register[k] && converter_control_register[ppm_pkg::BIT_CONV_ON]
          && converter_channel_select == 3'(k))
      begin
        next_fn.analog_switch[k] = 1'b1;
        if (k >= 4)
          next_owned[ppm_pkg::PIN_P30 + k] = 1'b1;
        else
          next_owned[ppm_pkg::PIN_P40 + k] = 1'b1;
      end
      else if (k < 4 && irq_enable_register_one[ppm_pkg::BIT_EX4]
               && irq_source_enable_register[k] && !pin_direction_bits[ppm_pkg::PIN_P40 + k])
      begin
        next_owned[ppm_pkg::PIN_P40 + k] = 1'b1;
        next_fn.port_four_irq_inputs[k] = pin_sync[ppm_pkg::PIN_P40 + k];
      end
    end

    if (converter_control_register[ppm_pkg::BIT_REF_SEL])
    begin
      next_owned[ppm_pkg::PIN_P44] = 1'b1;
      next_fn.converter_reference_input = 1'b1;
    end

    if (osc_option)
    begin
      next_owned[ppm_pkg::PIN_P50] = 1'b1;
      next_owned[ppm_pkg::PIN_P51] = 1'b1;
    end
    if (reset_option)
    begin
      next_owned[ppm_pkg::PIN_P52] = 1'b1;
      next_fn.reset_pin_input = pin_sync[ppm_pkg::PIN_P52];
    end

    if (buzzer_control_register[ppm_pkg::BIT_BUZ_EN])
    begin
      next_owned[ppm_pkg::PIN_P53] = 1'b1;
      next_pad.out[ppm_pkg::PIN_P53] = src.buzzer_output;
      next_pad.oe[ppm_pkg::PIN_P53]  = 1'b1;
    end
    else if (timer_three_control_register[ppm_pkg::BIT_T3_RUN]
             && timer_three_clock_select == ppm_pkg::T3_CLKS_PIN)
    begin
      next_owned[ppm_pkg::PIN_P53] = 1'b1;
      next_pad.oe[ppm_pkg::PIN_P53] = 1'b0;
      next_pad.pu[ppm_pkg::PIN_P53] = 1'b1;
      next_fn.timer_three_clock_input = pin_sync[ppm_pkg::PIN_P53];
    end

    // Owned input-style pins release port drive and port pull-up; the latched
    // direction, pull-up and data values reappear only once ownership ends.
    for (int i = 0; i < 48; i++)
    begin
      if (next_owned[i] && !(i == ppm_pkg::PIN_P02 || i == ppm_pkg::PIN_P21
          || (i == ppm_pkg::PIN_P03 && pwm_enable_register[ppm_pkg::BIT_PWM_PRI])
          || (i == ppm_pkg::PIN_P53 && buzzer_control_register[ppm_pkg::BIT_BUZ_EN])))
      begin
        next_pad.oe[i]  = 1'b0;
        next_pad.out[i] = 1'b0;
        if (!(i == ppm_pkg::PIN_P20 || i == ppm_pkg::PIN_P53
            || (i == ppm_pkg::PIN_P03 && t4_auto_pull)))
          next_pad.pu[i] = 1'b0;
      end
      else if (next_owned[i])
        next_pad.pu[i] = 1'b0;
    end
  end

  // Registered pad and function state; any enable change shows one cycle later.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pad   <= '0;
      fn    <= '0;
      owned <= '0;
    end
    else
    begin
      pad   <= next_pad;
      fn    <= next_fn;
      owned <= next_owned;
    end
  end

endmodule

/* hw/ppm_pkg.sv */
// Purpose: Shared constants and carriers of the port pin function priority mux.
// Assumes: APB register map with 32-bit data, one aligned word per register.
// Notes:   Pin index is port number times eight plus bit number.
package ppm_pkg;

  localparam int PIN_W = 48;

  // Pins that exist on each port; absent bits read as zero.
  localparam logic [47:0] PIN_VALID = 48'h0F1FFF631FCC;

  localparam logic [7:0] OFF_DATA_BASE  = 8'h00;
  localparam logic [7:0] OFF_DIR_BASE   = 8'h18;
  localparam logic [7:0] OFF_PULL_BASE  = 8'h30;
  localparam logic [7:0] OFF_PWM_EN     = 8'h48;
  localparam logic [7:0] OFF_T4_CTRL    = 8'h4C;
  localparam logic [7:0] OFF_IRQ_EN1    = 8'h50;
  localparam logic [7:0] OFF_IRQ_SRC    = 8'h54;
  localparam logic [7:0] OFF_SER_CTRL   = 8'h58;
  localparam logic [7:0] OFF_SER_TXBUF  = 8'h5C;
  localparam logic [7:0] OFF_AN_CHAN    = 8'h60;
  localparam logic [7:0] OFF_CONV_CTRL  = 8'h64;
  localparam logic [7:0] OFF_BUZ_CTRL   = 8'h68;
  localparam logic [7:0] OFF_T3_CTRL    = 8'h6C;
  localparam logic [7:0] OFF_OWN_LO     = 8'h70;
  localparam logic [7:0] OFF_OWN_HI     = 8'h74;
  localparam logic [7:0] OFF_LEVEL_LO   = 8'h78;
  localparam logic [7:0] OFF_LEVEL_HI   = 8'h7C;
  localparam logic [7:0] OFF_OPTION     = 8'h80;

  localparam logic [7:0] PORT_RST = 8'h00;
  localparam logic [7:0] CTRL_RST = 8'h00;

  localparam int BIT_PWM_SEC   = 0;
  localparam int BIT_PWM_PRI   = 1;
  localparam int BIT_FLT_EN    = 2;
  localparam int BIT_T4_RUN    = 0;
  localparam int BIT_T4_CLKS   = 1;
  localparam int BIT_T4_CNTS   = 2;
  localparam int BIT_T4_MODE2  = 3;
  localparam int BIT_EX2       = 0;
  localparam int BIT_EX3       = 1;
  localparam int BIT_EX4       = 2;
  localparam int BIT_RX_EN     = 0;
  localparam int BIT_TX_REL    = 1;
  localparam int BIT_CONV_ON   = 0;
  localparam int BIT_REF_SEL   = 1;
  localparam int POS_CONV_SCH  = 2;
  localparam int BIT_BUZ_EN    = 0;
  localparam int BIT_T3_RUN    = 0;
  localparam int POS_T3_CLKS   = 1;
  localparam logic [1:0] T3_CLKS_PIN = 2'h1;

  localparam int PIN_P02 = 2;
  localparam int PIN_P03 = 3;
  localparam int PIN_P06 = 6;
  localparam int PIN_P07 = 7;
  localparam int PIN_P20 = 16;
  localparam int PIN_P21 = 17;
  localparam int PIN_P25 = 21;
  localparam int PIN_P30 = 24;
  localparam int PIN_P40 = 32;
  localparam int PIN_P44 = 36;
  localparam int PIN_P50 = 40;
  localparam int PIN_P51 = 41;
  localparam int PIN_P52 = 42;
  localparam int PIN_P53 = 43;

  typedef struct packed {
    logic [47:0] out;
    logic [47:0] oe;
    logic [47:0] pu;
  } ppm_pad_t;

  typedef struct packed {
    logic pwm_primary_output;
    logic pwm_secondary_output;
    logic serial_tx_data;
    logic buzzer_output;
  } ppm_src_t;

  typedef struct packed {
    logic       ext_irq_two_input;
    logic       ext_irq_three_input;
    logic       timer_four_control_input;
    logic       serial_rx_data;
    logic       pwm_fault_input;
    logic       timer_three_clock_input;
    logic [3:0] port_four_irq_inputs;
    logic [7:0] analog_switch;
    logic       converter_reference_input;
    logic       oscillator_select;
    logic       reset_pin_select;
    logic       reset_pin_input;
  } ppm_fn_t;

endpackage

/* test/ppm_pin_mux_assertions.sv */
// Purpose: Port-level checks of the pin function priority mux.
// Assumes: Pad and function outputs are registered one edge after their cause.
// Notes:   Owned bits are the only view of ownership, so most checks key on them.
`timescale 1ns/1ps
module ppm_pin_mux_assertions (
  input logic              pclk,
  input logic              presetn,
  input logic              psel,
  input logic              penable,
  input logic [7:0]        paddr,
  input logic              pready,
  input logic              pslverr,
  input logic [47:0]       pin_in,
  input ppm_pkg::ppm_pad_t pad,
  input ppm_pkg::ppm_src_t src,
  input ppm_pkg::ppm_fn_t  fn,
  input logic [47:0]       owned
);
  // P1.0-P1.4, P2.6 and P3.0-P3.3 have no second function.
  localparam logic [47:0] UNSHARED = 48'h00000F401F00;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  pri_pwm_a: assert property (owned[3] && pad.oe[3] |-> fn.timer_four_control_input
    && pad.out[3] == $past(src.pwm_primary_output)) else $error("primary pwm lost");
  sec_pwm_a: assert property (owned[2] |-> pad.oe[2]
    && pad.out[2] == $past(src.pwm_secondary_output)) else $error("secondary pwm lost");
  tx_out_a: assert property (owned[17] |-> pad.oe[17]
    && pad.out[17] == $past(src.serial_tx_data)) else $error("transmit pin lost");
  buz_out_a: assert property (owned[43] && pad.oe[43] |-> fn.timer_three_clock_input
    && pad.out[43] == $past(src.buzzer_output)) else $error("buzzer pin lost");
  rx_pull_a: assert property (owned[16] |-> pad.pu[16] && !pad.oe[16]
    && fn.serial_rx_data == $past(pin_in[16], 3)) else $error("receive pin wrong");
  fault_in_a: assert property (owned[21] |-> !pad.oe[21]
    && fn.pwm_fault_input == $past(pin_in[21], 3)) else $error("fault pin wrong");
  fault_idle_a: assert property ($past(presetn) && !owned[21] |-> fn.pwm_fault_input)
    else $error("fault input not idle");
  ana_own_a: assert property ((fn.analog_switch & ~{owned[31:28], owned[35:32]}) == 8'h00)
    else $error("analog switch on unowned pin");
  ana_first_a: assert property ((fn.analog_switch[3:0] & ~fn.port_four_irq_inputs) == 4'h0)
    else $error("irq sees analog pin");
  plain_pin_a: assert property ((owned & UNSHARED) == 48'h000000000000)
    else $error("unshared pin owned");
  pull_in_a: assert property ((pad.pu & pad.oe) == 48'h000000000000)
    else $error("pull-up on driven pin");
  ref_pin_a: assert property (fn.converter_reference_input |-> owned[36] && !pad.oe[36])
    else $error("reference pin not held");
  rst_pin_a: assert property ($past(presetn) && !fn.reset_pin_select |-> fn.reset_pin_input)
    else $error("reset pin input active");
  bus_err_a: assert property (psel && penable && paddr > 8'h80 |-> pslverr && pready)
    else $error("unmapped access not refused");
endmodule
bind ppm_pin_mux ppm_pin_mux_assertions u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr), .pin_in(pin_in),
  .pad(pad), .src(src), .fn(fn), .owned(owned));

/* test/ppm_board.sv */
// Purpose: Peripherals and board around the pins of the mux.
// Assumes: Peripheral outputs share pclk with the mux.
// Notes:   Sources toggle at different rates so a swapped source shows.
`timescale 1ns/1ps
module ppm_board (
  input  logic              pclk,
  input  logic              presetn,
  input  ppm_pkg::ppm_pad_t pad,
  input  logic [47:0]       board,
  output logic [47:0]       pin_in,
  output ppm_pkg::ppm_src_t src
);
  logic [3:0] cnt;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cnt <= 4'h0;
    else
      cnt <= cnt + 4'h1;
  end
  assign src = ppm_pkg::ppm_src_t'(cnt);
  // Driven level wins, then the pull-up, then whatever the board holds.
  assign pin_in = (pad.oe & pad.out) | (~pad.oe & (pad.pu | board));
endmodule

/* test/test_ppm_pin_mux.sv */
// Purpose: Register-driven tests of pin ownership and priority.
// Assumes: APB slave answers through pready; pads settle one edge after a write.
// Notes:   Board levels are fixed so synced pin inputs are predictable.
`timescale 1ns/1ps
module test_ppm_pin_mux;
  logic              pclk;
  logic              presetn;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic              pready;
  logic              pslverr;
  logic              err_bus;
  logic [7:0]        paddr;
  logic [31:0]       pwdata;
  logic [31:0]       prdata;
  logic [31:0]       rd;
  logic [47:0]       pin_in;
  logic [47:0]       owned;
  logic [47:0]       board;
  logic              osc_s;
  logic              rst_s;
  ppm_pkg::ppm_pad_t pad;
  ppm_pkg::ppm_src_t src;
  ppm_pkg::ppm_fn_t  fn;
  int                err_total;
  int                compares;
  logic [5:0]        t4tab [4] = '{6'h04, 6'h12, 6'h26, 6'h0F};
  ppm_pin_mux dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pin_in(pin_in), .pad(pad), .src(src), .fn(fn), .owned(owned),
    .osc_option_strap(osc_s), .reset_option_strap(rst_s));
  ppm_board u_board (.pclk(pclk), .presetn(presetn), .pad(pad), .board(board),
    .pin_in(pin_in), .src(src));
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd      = prdata;
    err_bus = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
    repeat (2) @(posedge pclk);
    #1;
  endtask
  task automatic chk(input string nm, input logic [47:0] seen, input logic [47:0] exp);
    compares++;
    if (seen !== exp)
    begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic give_verdict();
    if (err_total == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  initial
  begin
    repeat (3000) @(posedge pclk);
    err_total++;
    give_verdict();
  end
  initial
  begin
    presetn = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h00000000;
    board   = 48'hA5A55A5A0F0F;
    osc_s   = 1'b1;
    rst_s   = 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    xfer(1'b0, ppm_pkg::OFF_PWM_EN, 32'h0);
    chk("pwm_en", {16'h0, rd}, 48'h0);
    // Straps are captured on the third edge after reset and owned follows one edge later.
    repeat (2) @(posedge pclk);
    #1;
    chk("owned", owned, 48'h030000000000);
    foreach (t4tab[i])
    begin
      wr(ppm_pkg::OFF_T4_CTRL, {28'h0, t4tab[i][5:2]});
      chk("t4", {46'h0, owned[3], pad.pu[3]}, {46'h0, t4tab[i][1:0]});
    end
    wr(ppm_pkg::OFF_DIR_BASE, 32'h08);
    wr(ppm_pkg::OFF_DATA_BASE, 32'h08);
    chk("p03", {45'h0, pad.oe[3], pad.out[3], pad.pu[3]}, 48'h1);
    wr(ppm_pkg::OFF_PWM_EN, 32'h07);
    chk("own", owned & 48'h20000C, 48'h20000C);
    chk("oe", pad.oe & 48'h20000C, 48'h00000C);
    chk("pu", pad.pu & 48'h8, 48'h0);
    xfer(1'b0, ppm_pkg::OFF_DATA_BASE, 32'h0);
    chk("p0", {16'h0, rd}, 48'h8);
    wr(ppm_pkg::OFF_PWM_EN, 32'h00);
    chk("p03", {45'h0, pad.oe[3], pad.out[3], pad.pu[3]}, 48'h1);
    wr(ppm_pkg::OFF_T4_CTRL, 32'h00);
    chk("p03", {45'h0, pad.oe[3], pad.out[3], pad.pu[3]}, 48'h6);
    wr(ppm_pkg::OFF_DIR_BASE, 32'h00);
    wr(ppm_pkg::OFF_IRQ_EN1, 32'h03);
    chk("irq", owned & 48'hC0, 48'hC0);
    wr(ppm_pkg::OFF_DIR_BASE, 32'h40);
    chk("irq", owned & 48'hC0, 48'h80);
    chk("int", {46'h0, fn.ext_irq_two_input, fn.ext_irq_three_input}, 48'h2);
    wr(ppm_pkg::OFF_SER_CTRL, 32'h01);
    chk("rx", {owned & 48'h30000} | {pad.pu & 48'h10000}, 48'h10000);
    wr(ppm_pkg::OFF_SER_TXBUF, 32'h55);
    chk("tx", {owned & 48'h30000} | {pad.oe & 48'h30000}, 48'h30000);
    wr(ppm_pkg::OFF_IRQ_EN1, 32'h04);
    wr(ppm_pkg::OFF_IRQ_SRC, 32'h0F);
    wr(ppm_pkg::OFF_AN_CHAN, 32'hFF);
    wr(ppm_pkg::OFF_CONV_CTRL, 32'h17);
    chk("ana", owned & 48'h1FF0000000, 48'h1F20000000);
    chk("sw", {40'h0, fn.analog_switch}, 48'h20);
    wr(ppm_pkg::OFF_CONV_CTRL, 32'h05);
    chk("ana", owned & 48'h1FF0000000, 48'h0F00000000);
    chk("irq4", {44'h0, fn.port_four_irq_inputs}, 48'h7);
    wr(ppm_pkg::OFF_T3_CTRL, 32'h03);
    chk("p53", {45'h0, owned[43], pad.oe[43], pad.pu[43]}, 48'h5);
    wr(ppm_pkg::OFF_BUZ_CTRL, 32'h01);
    chk("p53", {45'h0, owned[43], pad.oe[43], pad.pu[43]}, 48'h6);
    wr(ppm_pkg::OFF_BUZ_CTRL, 32'h00);
    wr(ppm_pkg::OFF_T3_CTRL, 32'h05);
    chk("p53", {47'h0, owned[43]}, 48'h0);
    wr(ppm_pkg::OFF_DIR_BASE + 8'h04, 32'h01);
    wr(ppm_pkg::OFF_DATA_BASE + 8'h04, 32'h01);
    wr(ppm_pkg::OFF_PULL_BASE + 8'h04, 32'h03);
    chk("p1", {42'h0, pad.oe[9:8], pad.out[9:8], pad.pu[9:8]}, 48'h16);
    xfer(1'b0, 8'hF0, 32'h0);
    chk("unmapped", {15'h0, rd, err_bus}, 48'h1);
    // Straps are only read after a reset, so the other option needs a second one.
    presetn <= 1'b0;
    osc_s   <= 1'b0;
    rst_s   <= 1'b1;
    board   <= 48'h000000000000;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (6) @(posedge pclk);
    #1;
    chk("owned", owned, 48'h040000000000);
    chk("opt", {45'h0, fn.oscillator_select, fn.reset_pin_select, fn.reset_pin_input},
      48'h2);
    give_verdict();
  end
endmodule
